// File: core/gptc_timer.v
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "gptc_regs.vh"

module gptc_timer (
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire        count_pin_in,
  input  wire [3:0]  capture_pin_in,
  output reg  [3:0]  match_pin_out,
  output reg  [1:0]  dma_req_out,
  output reg         irq_out
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Map, one 32-bit word per register, byte addresses:
  //   CTRL     enable, hold-in-reset, counter mode
  //   COUNT    main counter, writable while running
  //   PRESCALE terminal value of the prescale counter
  //   PRECNT   prescale counter, read only
  //   MCTRL    three bits per match: stop, reset, interrupt
  //   EMCTRL   two bits per pin action, pin levels read back above them
  //   CCTRL    four bits per capture: rise, fall, interrupt, clear
  //   PWMCTRL  per-channel PWM select and PWM mode enable
  //   DMACTRL  request enables for matches 0 and 1
  //   STATUS   sticky events, write one to clear
  //   MASK     interrupt enables, same layout as STATUS
  //   MATCH0-3 compare values, CAPT0-3 captured counts
  //   Reset values are all zero: counter disabled, pins low, no events
  //   Unused upper bits read as zero and ignore writes
  // Unmapped offsets answer with an error and read back as zero.
  // The count keeps running while software reads it; a read is a snapshot.

  reg  [2:0]   ctrl_r;
  reg  [31:0]  count_r;
  reg  [31:0]  prescale_r;
  reg  [31:0]  precnt_r;
  reg  [11:0]  mctrl_r;    // Per match: stop, reset, irq
  reg  [7:0]   emctrl_r;   // Per match: 2-bit output action
  reg  [15:0]  cctrl_r;    // Per capture: rise, fall, irq, clear
  reg  [3:0]   pwmctrl_r;  // Bits 2:0 channel PWM enable
  reg  [1:0]   dmactrl_r;
  reg  [7:0]   status_r;
  reg  [7:0]   mask_r;
  reg  [31:0]  match_r [0:3];
  reg  [31:0]  capt_r  [0:3];

  // ------------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------------
  reg  [4:0]   sync1_r;
  reg  [4:0]   sync2_r;
  reg  [4:0]   sync3_r;  // Previous synced level for edge detection

  // First stage feeds only the second stage
  // Third stage only remembers the last synced level; edges are
  // seen two to three clocks after the pin moves
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
      sync3_r <= 5'h00;
    end else begin
      sync1_r <= {count_pin_in, capture_pin_in};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  wire [3:0] cap_rise = sync2_r[3:0] & ~sync3_r[3:0];
  wire [3:0] cap_fall = ~sync2_r[3:0] & sync3_r[3:0];
  wire       ext_tick = sync2_r[4] & ~sync3_r[4];

  // ------------------------------------------------------------------
  // Counting clock, matches and captures
  // ------------------------------------------------------------------
  // Timer mode ticks every clock; counter mode ticks on external rising edges only.
  // Edges closer than about one clock apart may merge in the synchroniser,
  // so the external count input must be well below half the clock.
  wire tick = ctrl_r[`GPTC_CTRL_EN] & ~ctrl_r[`GPTC_CTRL_RST] &
              (ctrl_r[`GPTC_CTRL_CNTMODE] ? ext_tick : 1'b1);
  // Prescaler compare: a value of zero makes every counting clock a step
  wire step = tick & (precnt_r == prescale_r);

  reg  [3:0] cap_ev;
  reg  [3:0] cap_clr;
  reg  [3:0] match_hit;
  integer    i;

  // Edge-selected capture events and match detection
  always @* begin
    cap_ev    = 4'h0;
    cap_clr   = 4'h0;
    match_hit = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      cap_ev[i]    = (cctrl_r[4*i] & cap_rise[i]) | (cctrl_r[4*i+1] & cap_fall[i]);
      cap_clr[i]   = cap_ev[i] & cctrl_r[4*i+3];
      match_hit[i] = step & (count_r == match_r[i]);
    end
  end

  // Per-channel control bits gathered into one vector per action
  reg  [3:0] stop_sel;
  reg  [3:0] reset_sel;
  reg  [3:0] mirq_sel;
  reg  [3:0] cirq_sel;
  integer    k;

  // Match fields are three bits apart, capture fields four
  always @* begin
    stop_sel  = 4'h0;
    reset_sel = 4'h0;
    mirq_sel  = 4'h0;
    cirq_sel  = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      stop_sel[k]  = mctrl_r[3*k];
      reset_sel[k] = mctrl_r[3*k+1];
      mirq_sel[k]  = mctrl_r[3*k+2];
      cirq_sel[k]  = cctrl_r[4*k+2];
    end
  end

  // Match fires on the step that finds the count on the match value
  wire [3:0] stop_hit  = match_hit & stop_sel;
  wire [3:0] reset_hit = match_hit & reset_sel;
  wire [3:0] mirq_hit  = match_hit & mirq_sel;
  wire [3:0] cirq_hit  = cap_ev & cirq_sel;
  // In PWM mode the fourth match ends the cycle.
  // Limitation: a PWM match value above the period never fires, so that
  // channel stays low for the whole cycle.
  wire       pwm_wrap  = pwmctrl_r[3] & match_hit[3];

  // ------------------------------------------------------------------
  // APB slave, zero wait states
  // ------------------------------------------------------------------
  // Writes commit in the access cycle; reads are looked up in the setup cycle
  // so the data is settled by the time pready is sampled
  wire        wr_en = psel_in & penable_in & pwrite_in;
  wire        rd_en = psel_in & ~penable_in & ~pwrite_in;
  reg  [31:0] rd_nxt;
  reg         err_nxt;

  // Read mux; unmapped addresses answer with an error
  // Match and capture banks decode on address bits 3:2
  always @* begin
    rd_nxt  = `GPTC_ZERO32;
    err_nxt = 1'b0;
    case (paddr_in)
      `GPTC_CTRL:     rd_nxt = {29'h0, ctrl_r};
      `GPTC_COUNT:    rd_nxt = count_r;
      `GPTC_PRESCALE: rd_nxt = prescale_r;
      `GPTC_PRECNT:   rd_nxt = precnt_r;
      `GPTC_MCTRL:    rd_nxt = {20'h0, mctrl_r};
      `GPTC_EMCTRL:   rd_nxt = {20'h0, match_pin_out, emctrl_r};
      `GPTC_CCTRL:    rd_nxt = {16'h0, cctrl_r};
      `GPTC_PWMCTRL:  rd_nxt = {28'h0, pwmctrl_r};
      `GPTC_DMACTRL:  rd_nxt = {30'h0, dmactrl_r};
      `GPTC_STATUS:   rd_nxt = {24'h0, status_r};
      `GPTC_MASK:     rd_nxt = {24'h0, mask_r};
      12'h040, 12'h044, 12'h048, 12'h04C: rd_nxt = match_r[paddr_in[3:2]];
      12'h050, 12'h054, 12'h058, 12'h05C: rd_nxt = capt_r[paddr_in[3:2]];
      default:        err_nxt = 1'b1;
    endcase
  end

  // Read data registered in setup phase; pready high in access phase
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_out  <= `GPTC_ZERO32;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & err_nxt;
      if (rd_en) begin
        prdata_out <= rd_nxt;
      end
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  integer ch_cfg;

  // Captured values and the status bits are owned by hardware and are not
  // written here; unmapped writes fall through to the default and are dropped
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prescale_r <= `GPTC_ZERO32;
      mctrl_r    <= 12'h000;
      emctrl_r   <= 8'h00;
      cctrl_r    <= 16'h0000;
      pwmctrl_r  <= 4'h0;
      dmactrl_r  <= 2'h0;
      mask_r     <= 8'h00;
      for (ch_cfg = 0; ch_cfg < 4; ch_cfg = ch_cfg + 1) begin
        match_r[ch_cfg] <= `GPTC_ZERO32;
      end
    end else if (wr_en) begin
      case (paddr_in)
        `GPTC_PRESCALE: prescale_r <= pwdata_in;
        `GPTC_MCTRL:    mctrl_r    <= pwdata_in[11:0];
        `GPTC_EMCTRL:   emctrl_r   <= pwdata_in[7:0];
        `GPTC_CCTRL:    cctrl_r    <= pwdata_in[15:0];
        `GPTC_PWMCTRL:  pwmctrl_r  <= pwdata_in[3:0];
        `GPTC_DMACTRL:  dmactrl_r  <= pwdata_in[1:0];
        `GPTC_MASK:     mask_r     <= pwdata_in[7:0];
        12'h040, 12'h044, 12'h048, 12'h04C: match_r[paddr_in[3:2]] <= pwdata_in;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Counter, prescaler and control
  // ------------------------------------------------------------------
  // A stop and a software enable in one cycle: the stop is kept, so software
  // must re-enable after reading the halted count.
  // Priority: hold-in-reset or clearing capture, then a software
  // write of the count, then normal counting
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_r   <= 3'h0;
      count_r  <= `GPTC_ZERO32;
      precnt_r <= `GPTC_ZERO32;
    end else begin
      if (wr_en && paddr_in == `GPTC_CTRL) begin
        ctrl_r <= pwdata_in[2:0];
      end
      if (|stop_hit) begin
        ctrl_r[`GPTC_CTRL_EN] <= 1'b0;
      end
      if (ctrl_r[`GPTC_CTRL_RST] || (|cap_clr)) begin
        count_r  <= `GPTC_ZERO32;
        precnt_r <= `GPTC_ZERO32;
      end else if (wr_en && paddr_in == `GPTC_COUNT) begin
        count_r <= pwdata_in;
      end else if (tick) begin
        if (step) begin
          precnt_r <= `GPTC_ZERO32;
          if ((|reset_hit) || pwm_wrap) begin
            count_r <= `GPTC_ZERO32;
          end else if (|stop_hit) begin
            // A halting match leaves the count on the match value
            count_r <= count_r;
          end else begin
            count_r <= count_r + 32'h0000_0001;
          end
        end else begin
          precnt_r <= precnt_r + 32'h0000_0001;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Captures, outputs, DMA and interrupt
  // ------------------------------------------------------------------
  // Status write strobe and clear mask
  wire        stat_wr  = wr_en & (paddr_in == `GPTC_STATUS);
  wire [7:0]  stat_clr = stat_wr ? pwdata_in[7:0] : 8'h00;
  integer     ch_cap;
  integer     ch_pin;

  // Status: hardware set wins over write-one-to-clear in the same cycle,
  // so an event landing on the clear write is never lost
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_r <= 8'h00;
    end else begin
      status_r <= (status_r & ~stat_clr) | {cirq_hit, mirq_hit};
    end
  end

  // Interrupt is a registered level, one cycle behind status and mask
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_r & mask_r);
    end
  end

  // DMA requests are single-cycle pulses, one per match event
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dma_req_out <= 2'h0;
    end else begin
      dma_req_out <= match_hit[1:0] & dmactrl_r;
    end
  end

  // Capture registers take the count as it stands before any clear,
  // so a clearing edge still records the width just measured
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (ch_cap = 0; ch_cap < 4; ch_cap = ch_cap + 1) begin
        capt_r[ch_cap] <= `GPTC_ZERO32;
      end
    end else begin
      for (ch_cap = 0; ch_cap < 4; ch_cap = ch_cap + 1) begin
        if (cap_ev[ch_cap]) begin
          capt_r[ch_cap] <= count_r;
        end
      end
    end
  end

  // Match pins: PWM channels follow the cycle, others take the match action.
  // The fourth channel never runs PWM because its match sets the period.
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      match_pin_out <= 4'h0;
    end else begin
      for (ch_pin = 0; ch_pin < 4; ch_pin = ch_pin + 1) begin
        if (ch_pin < 3 && pwmctrl_r[3] && pwmctrl_r[ch_pin]) begin
          // PWM: low from cycle start until match, then high
          if (pwm_wrap) begin
            match_pin_out[ch_pin] <= 1'b0;
          end else if (match_hit[ch_pin]) begin
            match_pin_out[ch_pin] <= 1'b1;
          end
        end else if (match_hit[ch_pin]) begin
          case (emctrl_r[2*ch_pin +: 2])
            2'h1:    match_pin_out[ch_pin] <= 1'b0;
            2'h2:    match_pin_out[ch_pin] <= 1'b1;
            2'h3:    match_pin_out[ch_pin] <= ~match_pin_out[ch_pin];
            default: match_pin_out[ch_pin] <= match_pin_out[ch_pin];
          endcase
        end
      end
    end
  end

endmodule // gptc_timer

`default_nettype wire

// File: core/gptc_regs.vh
`ifndef GPTC_REGS_VH
`define GPTC_REGS_VH

// Register byte offsets
`define GPTC_CTRL     12'h000
`define GPTC_COUNT    12'h004
`define GPTC_PRESCALE 12'h008
`define GPTC_PRECNT   12'h00C
`define GPTC_MCTRL    12'h010
`define GPTC_EMCTRL   12'h014
`define GPTC_CCTRL    12'h018
`define GPTC_PWMCTRL  12'h01C
`define GPTC_DMACTRL  12'h020
`define GPTC_STATUS   12'h024
`define GPTC_MASK     12'h028
`define GPTC_MATCH0   12'h040
`define GPTC_CAPT0    12'h050

// Control fields
`define GPTC_CTRL_EN      0
`define GPTC_CTRL_RST     1
`define GPTC_CTRL_CNTMODE 2

// Status layout: bits 3:0 match, bits 7:4 capture
`define GPTC_STAT_W 8

// Reset values
`define GPTC_ZERO32 32'h0000_0000

`endif

// File: testbench/gptc_timer_properties.sv
`timescale 1ns/100ps
`default_nettype none
module gptc_timer_properties (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        count_pin_in,
  input wire logic [3:0]  capture_pin_in,
  input wire logic [3:0]  match_pin_out,
  input wire logic [1:0]  dma_req_out,
  input wire logic        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic wr_q;
  // Remember a write access; only software can release the interrupt
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) wr_q <= 1'b0;
    else wr_q <= psel_in && penable_in && pwrite_in;
  end
  sequence setup_s; psel_in && !penable_in; endsequence
  sequence answer_s; pready_out ##1 !pready_out; endsequence
  ready_answer_a: assert property (setup_s |=> answer_s)
    else $error("ready not a single pulse after setup");
  ready_access_a: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside an access phase");
  error_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  error_pulse_a: assert property (pslverr_out |=> !pslverr_out)
    else $error("error held too long");
  dma_pulse_a: assert property (|dma_req_out |=> dma_req_out == 2'h0)
    else $error("dma request longer than one cycle");
  reset_quiet_a: assert property ($fell(rst_in) |-> !irq_out && match_pin_out == 4'h0 && dma_req_out == 2'h0)
    else $error("outputs not quiet after reset");
  read_hold_a: assert property (!(psel_in && !penable_in && !pwrite_in) |=> $stable(prdata_out))
    else $error("read data changed without a read");
  irq_release_a: assert property ($fell(irq_out) |-> wr_q || $past(wr_q))
    else $error("interrupt dropped without a write");
endmodule // gptc_timer_properties
bind gptc_timer gptc_timer_properties i_props (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .count_pin_in, .capture_pin_in,
  .match_pin_out, .dma_req_out, .irq_out);
`default_nettype wire

// File: testbench/gptc_pins.sv
`timescale 1ns/100ps
`default_nettype none
module gptc_pins (
  input  wire logic       clk_in,
  input  wire logic       run_in,
  input  wire logic [3:0] cap_in,
  output var  logic       count_pin_out,
  output var  logic [3:0] capture_pin_out
);
  logic [1:0] div_r;
  initial begin
    div_r = 2'h0;
    count_pin_out = 1'b0;
    capture_pin_out = 4'h0;
  end
  // External count clock, one rise per 4 clocks; parked low when idle
  always @(posedge clk_in) begin
    div_r <= run_in ? div_r + 2'h1 : 2'h0;
    count_pin_out <= run_in && div_r[1];
    capture_pin_out <= cap_in;
  end
endmodule // gptc_pins
`default_nettype wire

// File: testbench/gptc_timer_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "gptc_regs.vh"
module gptc_timer_test;
  logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, run = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q, prdata_out;
  logic [3:0] cap = 0, capture_pin_in, match_pin_out;
  logic [1:0] dma_req_out;
  logic pready_out, pslverr_out, irq_out, count_pin_in;
  int bad_count = 0, comparisons = 0, cyc = 0;
  gptc_timer i_dut (.clk_in, .rst_in, .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out, .pready_out, .pslverr_out, .count_pin_in,
    .capture_pin_in, .match_pin_out, .dma_req_out, .irq_out);
  gptc_pins i_pins (.clk_in, .run_in(run), .cap_in(cap), .count_pin_out(count_pin_in),
    .capture_pin_out(capture_pin_in));
  always #5 clk_in = ~clk_in;
  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      stop_test;
    end
  end
  task automatic stop_test;
    $display("%0d compared, %0d wrong", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    tick(1);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    tick(1);
    penable <= 1'b1;
    do begin
      tick(1);
      n++;
    end while (pready_out !== 1'b1 && n < 16);
    if (n == 16) bad_count++;
    q = prdata_out;
    e = pslverr_out;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic t_stop;
    int n;
    n = 0;
    rd(`GPTC_COUNT, 32'h0);
    rd(12'h3FC, 32'h0);
    chk(e, 1);
    wr(`GPTC_PRESCALE, 32'h3);
    wr(`GPTC_MATCH0, 32'h5);
    wr(`GPTC_MCTRL, 32'h5);
    wr(`GPTC_MASK, 32'h1);
    wr(`GPTC_CTRL, 32'h1);
    while (irq_out !== 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk(n >= 20 && n <= 30, 1);
    tick(12);
    rd(`GPTC_COUNT, 32'h5);
    rd(`GPTC_CTRL, 32'h0);
    wr(`GPTC_MASK, 32'h0);
    tick(3);
    chk(irq_out, 0);
    wr(`GPTC_MASK, 32'h1);
    tick(3);
    chk(irq_out, 1);
    wr(`GPTC_STATUS, 32'h1);
    tick(3);
    chk(irq_out, 0);
    $display("stop test done");
  endtask
  task automatic t_reload;
    int dp, tg;
    logic p;
    int em[3] = '{2, 0, 1};
    dp = 0;
    tg = 0;
    wr(`GPTC_PRESCALE, 32'h0);
    wr(`GPTC_COUNT, 32'h0);
    wr(`GPTC_MCTRL, 32'h10);
    wr(`GPTC_MATCH0 + 12'h4, 32'h3);
    wr(`GPTC_EMCTRL, 32'hC);
    wr(`GPTC_DMACTRL, 32'h2);
    wr(`GPTC_CTRL, 32'h1);
    p = match_pin_out[1];
    repeat (40) begin
      tick(1);
      dp += dma_req_out[1];
      tg += (match_pin_out[1] != p);
      p = match_pin_out[1];
    end
    chk(dp >= 9 && dp <= 11, 1);
    chk(tg >= 9 && tg <= 11, 1);
    apb(1'b0, `GPTC_COUNT, 32'h0);
    chk(q <= 3, 1);
    for (int i = 0; i < 3; i++) begin
      wr(`GPTC_EMCTRL, 32'(em[i]) << 2);
      tick(10);
      chk(match_pin_out[1], em[i] != 1);
    end
    wr(`GPTC_MCTRL, 32'h0);
    $display("reload test done");
  endtask
  task automatic t_capture;
    logic [31:0] c;
    wr(`GPTC_CTRL, 32'h5);
    wr(`GPTC_COUNT, 32'h0);
    run <= 1'b1;
    tick(40);
    run <= 1'b0;
    tick(8);
    apb(1'b0, `GPTC_COUNT, 32'h0);
    c = q;
    chk(c >= 8 && c <= 11, 1);
    tick(20);
    rd(`GPTC_COUNT, c);
    wr(`GPTC_CCTRL, 32'h95);
    cap <= 4'h1;
    tick(8);
    rd(`GPTC_CAPT0, c);
    rd(`GPTC_STATUS, 32'h10);
    cap <= 4'h3;
    tick(8);
    rd(`GPTC_COUNT, 32'h0);
    $display("capture test done");
  endtask
  task automatic t_pwm;
    int hi;
    hi = 0;
    wr(`GPTC_COUNT, 32'h0);
    wr(`GPTC_MATCH0, 32'h4);
    wr(`GPTC_MATCH0 + 12'hC, 32'hA);
    wr(`GPTC_PWMCTRL, 32'h9);
    wr(`GPTC_CTRL, 32'h1);
    repeat (40) begin
      tick(1);
      hi += match_pin_out[0];
    end
    chk(hi >= 18 && hi <= 22, 1);
    $display("pwm test done");
  endtask
  initial begin
    tick(10);
    rst_in <= 1'b0;
    t_stop;
    t_reload;
    t_capture;
    t_pwm;
    stop_test;
  end
endmodule // gptc_timer_test
`default_nettype wire
